// ==== core/spi_defines.svh ====
/*
 * Register offsets, field positions, reset values and timing counts
 * for the serial port transfer-mode and status logic.
 * Assumes: included by bare name from the design files.
 */
`ifndef SPI_DEFINES_SVH
`define SPI_DEFINES_SVH

// special-function-register addresses
`define SPI_OFS_CFG2      8'hE9
`define SPI_OFS_STAT      8'hEA
`define SPI_OFS_TXBUF     8'h9A
`define SPI_OFS_RXBUF     8'h9B

// configuration-two field positions
`define SPI_CFG_MODE      0
`define SPI_CFG_LSBF      1
`define SPI_CFG_CPHA      2
`define SPI_CFG_CPOL      3
`define SPI_CFG_MASTER    4

// status field positions
`define SPI_ST_BUSY       7
`define SPI_ST_MCERR      6
`define SPI_ST_RXOF       5
`define SPI_ST_RXPEND     4

// reset values
`define SPI_CFG_RST       8'h00
`define SPI_BYTE_RST      8'h00

// half period of the generated serial clock, in clk cycles
`define SPI_HALF_DIV      4
// index of the last serial clock edge in one byte, counted from 0
`define SPI_EDGES_LAST    5'h0F

`endif

// ==== core/spi_pkg.sv ====
/*
 * Types shared by the serial port control and shift engine.
 * Assumes: nothing beyond a SystemVerilog compiler.
 */
package spi_pkg;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_RUN  = 3'b010,
        ENG_END  = 3'b100
    } eng_state_t;

endpackage

// ==== core/shift_if.sv ====
/*
 * Carrier between the register/control side and the shift engine.
 * Assumes: both modules run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface shift_if;
    logic       start;      // master byte start, one-cycle pulse
    logic [7:0] tx_byte;    // byte to shift out
    logic       lsb_first;
    logic       cpol;
    logic       cpha;
    logic       master;
    logic       sel;        // slave selected, synchronised level
    logic       busy;
    logic       done;       // byte complete, one-cycle pulse
    logic [7:0] rx_byte;

    modport ctrl   (output start, tx_byte, lsb_first, cpol, cpha, master,
                    sel, input busy, done, rx_byte);
    modport engine (input start, tx_byte, lsb_first, cpol, cpha, master,
                    sel, output busy, done, rx_byte);
endinterface

`default_nettype wire

// ==== core/spi_shifter.sv ====
/*
 * Byte shift engine: drives or follows the serial clock, shifts one
 * byte out and one byte in, in either bit order.
 * Assumes: pins arrive unsynchronised; reset is already synchronous
 * in release.
 */
`timescale 1ns/10ps
`default_nettype none
`include "spi_defines.svh"

module spi_shifter #(
    parameter int HALF = `SPI_HALF_DIV
) (
    input  wire logic clk,
    input  wire logic rst_n,
    shift_if.engine   sh,
    input  wire logic sclk_i,
    output logic      sclk_o,
    output logic      sclk_oe,
    input  wire logic mosi_i,
    output logic      mosi_o,
    output logic      mosi_oe,
    input  wire logic miso_i,
    output logic      miso_o,
    output logic      miso_oe
);
    import spi_pkg::*;

    typedef struct packed {
        eng_state_t st;
        logic [2:0] s1;     // first sync stage: sclk, mosi, miso
        logic [2:0] s2;
        logic       sprev;
        logic [7:0] div;
        logic [4:0] edges;
        logic       lvl;
        logic [7:0] tx;
        logic [7:0] rx;
        logic       outb;
        logic       done;
        logic [7:0] rxb;
    } eng_t;

    eng_t q, n;

    function automatic logic first_bit(input logic [7:0] v, input logic l);
        return l ? v[0] : v[7];
    endfunction

    function automatic logic [7:0] shl(input logic [7:0] v, input logic l);
        return l ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
    endfunction

    function automatic logic [7:0] sin(input logic [7:0] v, input logic d,
                                       input logic l);
        return l ? {d, v[7:1]} : {v[6:0], d};
    endfunction

    // clock generation or edge finding, then shift per edge
    always_comb begin
        logic       tick;
        logic       din;
        logic [7:0] rxn;
        tick = 1'b0;
        rxn = q.rx;
        n = q;
        n.done = 1'b0;
        n.s1 = {sclk_i, mosi_i, miso_i};
        n.s2 = q.s1;
        n.sprev = q.s2[2];
        din = sh.master ? q.s2[0] : q.s2[1];
        unique case (q.st)
            ENG_IDLE: begin
                if ((sh.master && sh.start) || (!sh.master && sh.sel)) begin
                    n.st = ENG_RUN;
                    n.tx = sh.tx_byte;
                    n.outb = first_bit(sh.tx_byte, sh.lsb_first);
                    n.edges = 5'h00;
                    n.div = 8'h00;
                    n.lvl = 1'b0;
                end
            end
            ENG_RUN: begin
                if (sh.master) begin
                    n.div = q.div + 8'h01;
                    if (q.div == 8'(HALF - 1)) begin
                        n.div = 8'h00;
                        tick = 1'b1;
                    end
                end else if (!sh.sel) begin
                    n.st = ENG_IDLE;    // deselect drops a partial byte
                end else begin
                    tick = (q.s2[2] != q.sprev);
                end
                if (tick) begin
                    n.lvl = ~q.lvl;
                    n.edges = q.edges + 5'h01;
                    if (q.edges[0] == sh.cpha) begin
                        rxn = sin(q.rx, din, sh.lsb_first);
                        n.rx = rxn;
                    end else if (q.edges != 5'h00) begin
                        n.tx = shl(q.tx, sh.lsb_first);
                        n.outb = first_bit(n.tx, sh.lsb_first);
                    end
                    if (q.edges == `SPI_EDGES_LAST) begin
                        if (sh.master) begin
                            n.st = ENG_END;
                        end else begin
                            n.done = 1'b1;
                            n.rxb = rxn;
                            n.edges = 5'h00;
                            n.tx = sh.tx_byte;
                            n.outb = first_bit(sh.tx_byte, sh.lsb_first);
                        end
                    end
                end
            end
            ENG_END: begin
                n.div = q.div + 8'h01;
                if (q.div == 8'(HALF - 1)) begin
                    n.st = ENG_IDLE;
                    n.done = 1'b1;
                    n.rxb = q.rx;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: ENG_IDLE, default: '0};
        end else begin
            q <= n;
        end
    end

    // pin and carrier outputs
    assign sclk_o = sh.cpol ^ q.lvl;
    assign sclk_oe = sh.master;
    assign mosi_o = q.outb;
    assign mosi_oe = sh.master;
    assign miso_o = q.outb;
    assign miso_oe = !sh.master && sh.sel;
    assign sh.busy = (q.st != ENG_IDLE);
    assign sh.done = q.done;
    assign sh.rx_byte = q.rxb;

    AST_FIRST_BIT: assert property (@(posedge clk) disable iff (!rst_n)
        (q.st == ENG_IDLE && sh.master && sh.start)
        |=> (q.outb == (sh.lsb_first ? $past(sh.tx_byte[0])
                                     : $past(sh.tx_byte[7]))))
        else $error("first bit out does not follow bit order");

endmodule // spi_shifter

`default_nettype wire

// ==== core/spi_port.sv ====
/*
 * Serial port transfer mode, bit order and interrupt status: register
 * access on the special-function-register bus, start and halt control,
 * receive buffer with pending and overflow flags, multi-controller
 * error detection and the interrupt request.
 * Assumes: one-cycle read and write strobes from the processor;
 * interrupt enable, select-input enable and overwrite enable come
 * from the rest of the port.
 */
`timescale 1ns/10ps
`default_nettype none
`include "spi_defines.svh"

module spi_port #(
    parameter int HALF = `SPI_HALF_DIV
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       irq_enable,
    input  wire logic       ss_input_enable,
    input  wire logic       overflow_overwrite_enable,
    output logic            irq,
    input  wire logic       sclk_i,
    output logic            sclk_o,
    output logic            sclk_oe,
    input  wire logic       mosi_i,
    output logic            mosi_o,
    output logic            mosi_oe,
    input  wire logic       miso_i,
    output logic            miso_o,
    output logic            miso_oe,
    input  wire logic       ss_n_i,
    output logic            ss_n_o,
    output logic            ss_n_oe
);
    import spi_pkg::*;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] txb;
        logic       tx_full;
        logic [7:0] rxb;
        logic       mm;
        logic       of;
        logic       pend;
        logic       halted;
        logic       ss1;
        logic       ss2;
        logic       ss_lo;
        logic       irq;
        logic       start;
        logic [7:0] rdata;
    } ctl_t;

    ctl_t     q, n;
    logic [1:0] rsync_q;
    logic     rst_q;
    shift_if  sh ();

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_q <= 2'b00;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_q = rsync_q[1];

    // decoded strobes and configuration fields
    logic rd_rx, wr_tx, wr_cfg, wr_st;
    logic mode1, master, ss_act, idle;
    assign rd_rx = sfr_rd && sfr_addr == `SPI_OFS_RXBUF;
    assign wr_tx = sfr_wr && sfr_addr == `SPI_OFS_TXBUF;
    assign wr_cfg = sfr_wr && sfr_addr == `SPI_OFS_CFG2;
    assign wr_st = sfr_wr && sfr_addr == `SPI_OFS_STAT;
    assign mode1 = q.cfg[`SPI_CFG_MODE];
    assign master = q.cfg[`SPI_CFG_MASTER];
    assign ss_act = !q.ss2;
    assign idle = !sh.busy && !q.start;

    function automatic logic [7:0] status(input ctl_t s, input logic b);
        logic [7:0] v;
        v = 8'h00;
        v[`SPI_ST_BUSY] = b;
        v[`SPI_ST_MCERR] = s.mm;
        v[`SPI_ST_RXOF] = s.of;
        v[`SPI_ST_RXPEND] = s.pend;
        return v;
    endfunction

    // register file, flags and transfer control
    always_comb begin
        n = q;
        n.start = 1'b0;
        n.ss1 = ss_n_i;
        n.ss2 = q.ss1;
        if (wr_cfg) begin
            n.cfg = sfr_wdata;
        end
        if (wr_tx) begin
            n.txb = sfr_wdata;
            n.tx_full = 1'b1;
        end
        // clears first so a same-cycle set wins
        if (rd_rx) begin
            n.of = 1'b0;
            n.pend = 1'b0;
            n.halted = 1'b0;
        end
        if (wr_st && sfr_wdata[`SPI_ST_MCERR]) begin
            n.mm = 1'b0;
        end
        if (master && idle && !mode1 && rd_rx) begin
            n.start = 1'b1;
        end
        if (master && idle && mode1 && wr_tx) begin
            n.start = 1'b1;
        end
        if (sh.done) begin
            if (q.pend && !rd_rx) begin
                n.of = 1'b1;
                if (overflow_overwrite_enable) begin
                    n.rxb = sh.rx_byte;
                end
                if (master && !mode1) begin
                    n.halted = 1'b1;
                end
            end else begin
                n.rxb = sh.rx_byte;
            end
            n.pend = 1'b1;
            if (!master) begin
                n.tx_full = 1'b0;
            end else if (mode1 && q.tx_full) begin
                n.start = 1'b1;
            end
        end
        if (n.start) begin
            n.tx_full = wr_tx && !q.tx_full ? 1'b0 : n.tx_full;
            if (!wr_tx || q.tx_full) begin
                n.tx_full = 1'b0;
            end
        end
        if (ss_input_enable && master && sh.busy && ss_act) begin
            n.mm = 1'b1;
        end
        // select low from the start pulse to the byte end, no gap while
        // the engine picks up the start; a streamed byte end lets it
        // rise for one cycle; released on halt
        n.ss_lo = master && !n.halted
                  && ((n.start && !sh.done) || q.start
                      || (sh.busy && !sh.done));
        n.irq = irq_enable && (mode1 ? !q.tx_full : q.pend);
        if (sfr_rd) begin
            unique case (sfr_addr)
                `SPI_OFS_CFG2:  n.rdata = q.cfg;
                `SPI_OFS_STAT:  n.rdata = status(q, sh.busy);
                `SPI_OFS_TXBUF: n.rdata = q.txb;
                `SPI_OFS_RXBUF: n.rdata = q.rxb;
                default:        n.rdata = 8'h00;
            endcase
        end
    end

    // state register, zero after reset except the select synchronisers, which reset high
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            q <= '{cfg: `SPI_CFG_RST, ss1: 1'b1, ss2: 1'b1,
                   default: '0};
        end else begin
            q <= n;
        end
    end

    // engine hookup
    assign sh.start = q.start;
    assign sh.tx_byte = q.txb;
    assign sh.lsb_first = q.cfg[`SPI_CFG_LSBF];
    assign sh.cpol = q.cfg[`SPI_CFG_CPOL];
    assign sh.cpha = q.cfg[`SPI_CFG_CPHA];
    assign sh.master = master;
    assign sh.sel = !master && ss_act;

    spi_shifter #(.HALF(HALF)) u_shift (
        .clk     (clk),
        .rst_n   (rst_q),
        .sh      (sh.engine),
        .sclk_i  (sclk_i),
        .sclk_o  (sclk_o),
        .sclk_oe (sclk_oe),
        .mosi_i  (mosi_i),
        .mosi_o  (mosi_o),
        .mosi_oe (mosi_oe),
        .miso_i  (miso_i),
        .miso_o  (miso_o),
        .miso_oe (miso_oe)
    );

    // port outputs
    assign sfr_rdata = q.rdata;
    assign irq = q.irq;
    assign ss_n_o = !q.ss_lo;
    assign ss_n_oe = master && !ss_input_enable;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q);

    AST_START_BUSY: assert property (q.start |=> sh.busy)
        else $error("busy not shown after start");

    AST_START_RD: assert property (
        master && !mode1 && idle && rd_rx |=> q.start ##1 sh.busy)
        else $error("receive read did not start a byte");

    AST_START_WR: assert property (
        master && mode1 && idle && wr_tx |=> q.start)
        else $error("transmit write did not start a byte");

    AST_MM_SET: assert property (
        ss_input_enable && master && sh.busy && ss_act |=> q.mm)
        else $error("multi controller error not flagged");

    AST_OF_SET: assert property (
        sh.done && q.pend && !rd_rx |=> q.of && q.pend)
        else $error("overflow not flagged");

    AST_OF_KEEP: assert property (
        sh.done && q.pend && !rd_rx && !overflow_overwrite_enable
        |=> $stable(q.rxb))
        else $error("buffered byte replaced without overwrite");

    AST_RD_CLR: assert property (
        rd_rx && !sh.done |=> !q.of && !q.pend)
        else $error("receive read did not clear flags");

    AST_PEND_SET: assert property (
        sh.done |=> q.pend && q.rxb == (q.of ? q.rxb : $past(sh.rx_byte)))
        else $error("pending not set on new data");

    AST_IRQ: assert property (
        irq_enable && !mode1 && $rose(q.pend) ##0 irq_enable && !wr_cfg
        |=> irq)
        else $error("interrupt request missing for pending data");

    AST_HALT: assert property (
        q.halted && !rd_rx |-> !n.start ##1 !q.ss_lo)
        else $error("halted port started or held select");

    AST_SS_HOLD: assert property (
        q.start && master && !n.halted |=> q.ss_lo)
        else $error("select not held after start");

    AST_BUSY_STAT: assert property (
        sfr_rd && sfr_addr == `SPI_OFS_STAT
        |=> sfr_rdata[`SPI_ST_BUSY] == $past(sh.busy))
        else $error("status busy bit does not follow engine");

    AST_MM_CLR: assert property (
        wr_st && sfr_wdata[`SPI_ST_MCERR]
        && !(ss_input_enable && master && sh.busy && ss_act) |=> !q.mm)
        else $error("multi controller error not cleared");

    AST_IRQ_TX: assert property (
        irq_enable && mode1 && !q.tx_full |=> irq)
        else $error("interrupt request missing for empty buffer");

    AST_HALT_RD: assert property (
        q.halted && rd_rx |=> !q.halted)
        else $error("receive read did not lift halt");

    AST_OF_OVW: assert property (
        sh.done && q.pend && !rd_rx && overflow_overwrite_enable
        |=> q.rxb == $past(sh.rx_byte))
        else $error("overwrite enabled but byte not replaced");

    AST_NO_START_BUSY: assert property (
        sh.busy |-> !q.start)
        else $error("start issued while engine busy");

    AST_PEND_HOLD: assert property (
        q.pend && !rd_rx |=> q.pend)
        else $error("pending flag lost without a read");

    AST_CFG_WR: assert property (
        wr_cfg |=> q.cfg == $past(sfr_wdata))
        else $error("configuration write not stored");

endmodule // spi_port

`default_nettype wire

// ==== dv/spi_slave_model.sv ====
/*
 * Behavioural far-end serial slave, clock polarity 0 and phase 0,
 * most significant bit first.
 * Assumes: select and clock come resolved from the bench pins.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_slave_model (
    input  wire logic       sclk,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic      [7:0] got,
    output int              count
);
    logic [7:0] sh_out;
    logic [7:0] sh_in;
    int         nbits;

    // start quiet
    initial begin
        miso  = 1'b0;
        got   = 8'h00;
        count = 0;
        nbits = 0;
    end

    // select: load reply, first bit out before any clock edge
    always @(negedge ss_n) begin
        sh_out = reply;
        miso   = reply[7];
        nbits  = 0;
    end

    // released line shows no stale value
    always @(posedge ss_n) begin
        miso = ~miso;
    end

    // sample on rising, same phase and polarity as the port
    always @(posedge sclk) begin
        if (!ss_n) begin
            sh_in = {sh_in[6:0], mosi};
            nbits++;
            if (nbits == 8) begin
                got   = sh_in;
                count++;
                nbits = 0;
            end
        end
    end

    // launch next bit on falling
    always @(negedge sclk) begin
        if (!ss_n) begin
            sh_out = {sh_out[6:0], 1'b0};
            miso   = sh_out[7];
        end
    end
endmodule // spi_slave_model

`default_nettype wire

// ==== dv/tb.sv ====
/*
 * Self-checking bench for spi_port as master against a slave model,
 * and as slave with the bench driving the serial clock.
 * Assumes: design files and the slave model compiled before this one.
 */
`timescale 1ns/10ps
`default_nettype none
`include "spi_defines.svh"

module tb;
    localparam int HALF = 10; // 80 ns serial clock

    logic        clk, rst_n, sfr_wr, sfr_rd, rd_d1, irq;
    logic        irq_enable, ss_input_enable, ovw_en, ss_drv;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, reply, got, tx, rp;
    logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic        ss_n_o, ss_n_oe, miso_m, sclk_m, mosi_m;
    logic [15:0] chk;
    logic [31:0] rnd;
    wire logic   sclk_w, mosi_w, miso_w, ss_w;
    int          fails, total_checks, nbytes;
    logic [15:0] exp_rd[$];
    logic [7:0]  exp_link[$];

    // pin resolution from all enables
    assign sclk_w = sclk_oe ? sclk_o : sclk_m;
    assign mosi_w = mosi_oe ? mosi_o : mosi_m;
    assign miso_w = miso_oe ? miso_o : miso_m;
    assign ss_w   = ss_n_oe ? ss_n_o : ss_drv;

    spi_port #(.HALF(HALF)) u_dut (
        .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .irq_enable(irq_enable), .ss_input_enable(ss_input_enable),
        .overflow_overwrite_enable(ovw_en), .irq(irq),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
        .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe)
    );

    spi_slave_model u_slave (
        .sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .reply(reply),
        .miso(miso_m), .got(got), .count(nbytes)
    );

    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [7:0] rev(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev[i] = b[7-i];
    endfunction

    task check(input logic [7:0] seen, input logic [7:0] want,
               input logic [7:0] mask);
        total_checks++;
        if (((seen ^ want) & mask) !== 8'h00) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
    endtask

    task sfr_read(input logic [7:0] a, input logic [7:0] want,
                  input logic [7:0] mask);
        exp_rd.push_back({mask, want});
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk);
        sfr_rd   <= 1'b0;
    endtask

    // one byte on the link, busy sampled mid-byte
    task automatic xfer(input logic [7:0] t, input logic [7:0] r,
                        input logic lsb, input logic [7:0] mid,
                        input logic by_read, input logic [7:0] old);
        int n0;
        int k;
        n0    = nbytes;
        reply = r;
        k     = 0;
        exp_link.push_back(lsb ? rev(t) : t);
        sfr_write(`SPI_OFS_TXBUF, t);
        if (by_read) sfr_read(`SPI_OFS_RXBUF, old, 8'hFF);
        repeat (4 * HALF) @(posedge clk);
        sfr_read(`SPI_OFS_STAT, mid, 8'hF0);
        while (nbytes == n0 && k < 1000) begin
            @(posedge clk);
            k++;
        end
        check(nbytes == n0 ? 8'h01 : 8'h00, 8'h00, 8'hFF);
        repeat (3 * HALF + 8) @(posedge clk);
    endtask

    // bench as controller: clock polarity 0, phase 0, msb first
    task automatic as_master(input logic [7:0] t, output logic [7:0] r);
        r = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            mosi_m <= t[b];
            repeat (HALF) @(posedge clk);
            sclk_m <= 1'b1;
            r = {r[6:0], miso_w};
            repeat (HALF) @(posedge clk);
            sclk_m <= 1'b0;
        end
    endtask

    // read results, oldest note first
    always @(posedge clk) begin
        if (rd_d1) begin
            chk = exp_rd.pop_front();
            check(sfr_rdata, chk[7:0], chk[15:8]);
        end
        rd_d1 <= sfr_rd;
    end

    // link bytes seen by the slave
    always @(nbytes) begin
        if (exp_link.size() > 0) begin
            check(got, exp_link.pop_front(), 8'hFF);
        end
    end

    task give_verdict;
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sclk_m = 1'b0;
        mosi_m = 1'b0;
        irq_enable = 1'b0;
        ss_input_enable = 1'b0;
        ovw_en = 1'b0;
        ss_drv = 1'b1;
        reply = 8'h00;
        fails = 0;
        total_checks = 0;
        rnd = 32'h4a39;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        sfr_read(`SPI_OFS_STAT, 8'h00, 8'hFF);
        sfr_read(`SPI_OFS_CFG2, 8'h00, 8'hFF);
        sfr_read(8'h55, 8'h00, 8'hFF);
        sfr_write(`SPI_OFS_CFG2, 8'h11);
        sfr_read(`SPI_OFS_CFG2, 8'h11, 8'hFF);
        irq_enable <= 1'b1;
        // write-started bytes, both bit orders
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            tx  = rnd[7:0];
            rnd = lfsr(rnd);
            rp  = rnd[7:0];
            sfr_write(`SPI_OFS_CFG2, i ? 8'h13 : 8'h11);
            xfer(tx, rp, i[0], 8'h80, 1'b0, 8'h00);
            check({7'h00, irq}, 8'h01, 8'hFF);
            sfr_read(`SPI_OFS_STAT, 8'h10, 8'hFF);
            sfr_read(`SPI_OFS_RXBUF, i ? rev(rp) : rp, 8'hFF);
        end
        // unread buffer overflows, kept then replaced
        sfr_write(`SPI_OFS_CFG2, 8'h11);
        for (int i = 0; i < 2; i++) begin
            ovw_en <= i[0];
            xfer(8'hA5, 8'h3C, 1'b0, 8'h80, 1'b0, 8'h00);
            xfer(8'h5A, 8'hC3, 1'b0, 8'h90, 1'b0, 8'h00);
            sfr_read(`SPI_OFS_STAT, 8'h30, 8'hFF);
            sfr_read(`SPI_OFS_RXBUF, i ? 8'hC3 : 8'h3C, 8'hFF);
            sfr_read(`SPI_OFS_STAT, 8'h00, 8'hFF);
        end
        // mode 0 taken mid-byte with data unread: port halts
        xfer(8'h24, 8'h42, 1'b0, 8'h80, 1'b0, 8'h00);
        reply = 8'h99;
        exp_link.push_back(8'hDB);
        sfr_write(`SPI_OFS_TXBUF, 8'hDB);
        sfr_write(`SPI_OFS_CFG2, 8'h10);
        repeat (200) @(posedge clk);
        sfr_read(`SPI_OFS_STAT, 8'h30, 8'hFF);
        check({7'h00, ss_w}, 8'h01, 8'hFF);
        // read-started byte lifts the halt, request follows pending
        xfer(8'h81, 8'h7E, 1'b0, 8'h80, 1'b1, 8'h99);
        check({7'h00, irq}, 8'h01, 8'hFF);
        irq_enable <= 1'b0;
        repeat (3) @(posedge clk);
        check({7'h00, irq}, 8'h00, 8'hFF);
        sfr_write(`SPI_OFS_CFG2, 8'h11);
        sfr_read(`SPI_OFS_RXBUF, 8'h7E, 8'hFF);
        // select driven by another controller mid-byte
        ss_input_enable <= 1'b1;
        sfr_write(`SPI_OFS_TXBUF, 8'h66);
        repeat (30) @(posedge clk);
        ss_drv <= 1'b0;
        repeat (10) @(posedge clk);
        ss_drv <= 1'b1;
        repeat (300) @(posedge clk);
        sfr_read(`SPI_OFS_STAT, 8'h40, 8'h40);
        sfr_write(`SPI_OFS_STAT, 8'h40);
        sfr_read(`SPI_OFS_STAT, 8'h00, 8'h40);
        // port as slave, unread byte from before overflows
        sfr_write(`SPI_OFS_CFG2, 8'h00);
        sfr_write(`SPI_OFS_TXBUF, 8'hC6);
        exp_link.push_back(8'h39);
        ss_drv <= 1'b0;
        as_master(8'h39, rp);
        repeat (8) @(posedge clk);
        ss_drv <= 1'b1;
        check(rp, 8'hC6, 8'hFF);
        repeat (8) @(posedge clk);
        sfr_read(`SPI_OFS_STAT, 8'h30, 8'hFF);
        sfr_read(`SPI_OFS_RXBUF, 8'h39, 8'hFF);
        repeat (5) @(posedge clk);
        give_verdict();
    end
endmodule // tb

`default_nettype wire
